// *** logic/adc_readout_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_readout_control
    import adc_readout_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    convert_strobe,
    input  wire logic                    select_chain_input,
    input  wire logic                    shift_clock,
    input  wire logic signed [RAW_W-1:0] raw_code,
    output logic                         serial_result_output,
    output logic                         serial_result_output_en,
    output logic                         converting,
    output logic                         powered_down,
    output logic                         chain_mode,
    output logic                         start_bit_enabled
);
    // Pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges and the delayed mode samples
    logic [2:0] cnv_sync_r;
    logic [2:0] sdi_sync_r;
    logic [2:0] sck_sync_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnv_sync_r <= 3'h0;
            sdi_sync_r <= 3'h0;
            sck_sync_r <= 3'h0;
        end else begin
            cnv_sync_r <= {cnv_sync_r[1:0], convert_strobe};
            sdi_sync_r <= {sdi_sync_r[1:0], select_chain_input};
            sck_sync_r <= {sck_sync_r[1:0], shift_clock};
        end
    end

    wire cnv_s    = cnv_sync_r[1];
    wire sdi_s    = sdi_sync_r[1];
    wire sck_s    = sck_sync_r[1];
    wire cnv_rise = cnv_s & ~cnv_sync_r[2];
    wire sck_fall = ~sck_s & sck_sync_r[2];

    state_t      state_r;
    state_t      state_nxt;
    logic [7:0]  conv_cnt_r;
    logic        cs_mode_r;
    logic        busy_en_r;
    logic        chain_busy_r;
    logic        loaded_r;
    logic [16:0] shreg_r;
    logic [4:0]  bit_cnt_r;
    logic [15:0] fifo_out;
    logic        fifo_out_valid;
    logic        fifo_in_ready;

    // Saturating two's complement coding of the comparator result
    wire over       = raw_code > $signed({{(RAW_W-RESULT_W){1'b0}}, CODE_MAX});
    wire under      = raw_code < $signed({{(RAW_W-RESULT_W){1'b1}}, CODE_MIN});
    wire [15:0] code = over ? CODE_MAX : under ? CODE_MIN :
                       raw_code[RESULT_W-1:0];

    wire conv_done  = (conv_cnt_r == 8'(CONV_CYCLES - 1));
    wire push       = (state_r == ST_CONV) & conv_done;
    wire end_conv   = push & fifo_in_ready;
    wire pop        = (state_r == ST_READ) & ~loaded_r & fifo_out_valid;
    wire cs_select  = ~cnv_s | ~sdi_s;
    wire selected   = cs_mode_r ? cs_select : 1'b1;
    wire [4:0] frame_len = busy_en_r ? FRAME_START : FRAME_PLAIN;
    wire frame_open = (state_r == ST_READ) & loaded_r &
                      (~cs_mode_r | bit_cnt_r < frame_len);
    wire start_conv = cnv_rise & (state_r != ST_CONV);
    wire busy_at_end = cs_mode_r ? cs_select : chain_busy_r;
    wire shift_in    = cs_mode_r ? 1'b0 : sdi_s;
    // Without a start bit the pad under the LSB must never reach the pin
    wire [16:0] shreg_shifted = busy_en_r ?
                                {shreg_r[15:0], shift_in} :
                                {shreg_r[15:1], shift_in, 1'b0};

    result_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (code),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_ACQ:  if (start_conv) state_nxt = ST_CONV;
            ST_CONV: if (end_conv) state_nxt = ST_READ;
            ST_READ: if (start_conv) state_nxt = ST_CONV;
            default: state_nxt = ST_ACQ;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r      <= ST_ACQ;
            conv_cnt_r   <= 8'h00;
            cs_mode_r    <= 1'b1;
            chain_busy_r <= 1'b0;
            busy_en_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (start_conv) begin
                conv_cnt_r   <= 8'h00;
                // Delayed select sample: a select tied to the strobe reads low
                cs_mode_r    <= sdi_sync_r[2];
                chain_busy_r <= sck_sync_r[2];
            end else if (state_r == ST_CONV && !conv_done) begin
                conv_cnt_r <= conv_cnt_r + 8'h01;
            end
            if (end_conv) begin
                busy_en_r <= busy_at_end;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loaded_r  <= 1'b0;
            shreg_r   <= 17'h00000;
            bit_cnt_r <= 5'h00;
        end else if (start_conv) begin
            loaded_r  <= 1'b0;
            bit_cnt_r <= 5'h00;
        end else if (pop) begin
            loaded_r  <= 1'b1;
            bit_cnt_r <= 5'h00;
            shreg_r   <= busy_en_r ? {START_BIT_VAL, fifo_out}
                                   : {fifo_out, 1'b0};
        end else if (frame_open && selected && sck_fall) begin
            shreg_r   <= shreg_shifted;
            bit_cnt_r <= (bit_cnt_r == 5'h1f) ? bit_cnt_r
                                              : bit_cnt_r + 5'h01;
        end else if (cs_mode_r && !cs_select && bit_cnt_r != 5'h00) begin
            // Deselect ends the frame early
            bit_cnt_r <= frame_len;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_result_output    <= 1'b0;
            serial_result_output_en <= 1'b0;
        end else begin
            serial_result_output    <= shreg_r[16];
            serial_result_output_en <= frame_open & selected;
        end
    end

    assign converting        = (state_r == ST_CONV);
    assign powered_down      = (state_r != ST_CONV);
    assign chain_mode        = ~cs_mode_r;
    assign start_bit_enabled = busy_en_r;
endmodule : adc_readout_control
`default_nettype wire

// *** logic/adc_readout_pkg.sv ***
// Summary of operation
// - Each result is a 16-bit two's complement word, 0x7fff top, 0x0000 mid, 0x8000 bottom.
// - Results above or below the input range clamp to 0x7fff or 0x8000.
// - The select/chain level at each convert rising edge that starts a conversion picks direct-select (high) or chain (low).
// - With select/chain tied to the convert strobe the mode always resolves as chain.
// - Either mode can prefix the result with a start bit that flags end of conversion.
// - In direct-select mode the start bit is enabled if strobe or select is low at conversion end.
// - In chain mode the start bit is enabled if the shift clock is high at the strobe rising edge.
// - The converter drops to low power at the end of every conversion.
// - 3-wire direct-select: the convert strobe going low also selects readback.
// - 4-wire direct-select: the select/chain input going low selects readback.
// - In chain mode select/chain data is shifted in behind the own result.
// - A conversion starts on a convert strobe rising edge after acquisition.
// - Conversion is timed by the internal clock, never by the shift clock.
// - A started conversion runs to its end whatever the strobe does.
// - Readback is MSB first, advancing on each shift clock falling edge.
package adc_readout_pkg;
    localparam int          RESULT_W      = 16;
    localparam int          RAW_W         = 18;
    localparam int          FIFO_DEPTH    = 32;
    localparam logic [15:0] CODE_MAX      = 16'h7fff;
    localparam logic [15:0] CODE_MIN      = 16'h8000;
    localparam logic [15:0] CODE_MID      = 16'h0000;
    localparam logic        START_BIT_VAL = 1'b0;
    localparam int          CLK_PERIOD_PS = 8000;
    localparam int          CONV_TIME_NS  = 500;
    localparam int          CONV_CYCLES   =
        (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [4:0]  FRAME_PLAIN   = 5'h10;
    localparam logic [4:0]  FRAME_START   = 5'h11;

    typedef enum logic [2:0] {
        ST_ACQ  = 3'b001,
        ST_CONV = 3'b010,
        ST_READ = 3'b100
    } state_t;
endpackage : adc_readout_pkg

// *** logic/result_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : result_fifo
`default_nettype wire

// *** testbench/adc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    input  wire logic clock,
    input  wire logic sro,
    input  wire logic sro_en,
    output var logic  strobe,
    output var logic  sel,
    output var logic  sck
);
    logic lvl;
    assign lvl = sro_en ? sro : 1'b1; // Pull-up while released
    initial begin
        strobe = 1'b0;
        sel = 1'b1;
        sck = 1'b0;
    end
    task automatic start(input logic s, k, tie, sa, ca);
        @(posedge clock);
        strobe <= 1'b0;
        sel <= s;
        sck <= k;
        repeat (4) @(posedge clock);
        strobe <= 1'b1;
        if (tie) sel <= 1'b1;
        repeat (4) @(posedge clock);
        strobe <= ca;
        sel <= sa;
        repeat (80) @(posedge clock);
    endtask : start
    task automatic read(input int n, input logic w, input logic [31:0] cd,
                        output logic [31:0] got);
        got = '0;
        @(posedge clock);
        if (w) sel <= 1'b0;
        else strobe <= 1'b0;
        repeat (8) @(posedge clock);
        sck <= 1'b1;
        for (int p = 0; p < n; p++) begin
            repeat (4) @(posedge clock);
            @(negedge clock);
            got[n-1-p] = lvl;
            @(posedge clock);
            sck <= 1'b0;
            if (!w) sel <= cd[n-1-p];
            repeat (5) @(posedge clock);
            sck <= 1'b1;
        end
    endtask : read
endmodule : adc_host_model
`default_nettype wire

// *** testbench/adc_readout_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_readout_assertions
    import adc_readout_pkg::*;
(
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic                    convert_strobe,
    input wire logic                    select_chain_input,
    input wire logic                    shift_clock,
    input wire logic signed [RAW_W-1:0] raw_code,
    input wire logic                    serial_result_output,
    input wire logic                    serial_result_output_en,
    input wire logic                    converting,
    input wire logic                    powered_down,
    input wire logic                    chain_mode,
    input wire logic                    start_bit_enabled
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_begin; $rose(converting); endsequence
    property p_sleep; powered_down == !converting; endproperty
    a_sleep: assert property (p_sleep) else $error("power state");
    property p_go; $rose(convert_strobe) && !converting |-> ##[1:4] converting;
    endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_hold; s_begin |-> converting[*8]; endproperty
    a_hold: assert property (p_hold) else $error("aborted");
    property p_len; s_begin |-> ##[60:66] $fell(converting); endproperty
    a_len: assert property (p_len) else $error("conversion length");
    property p_quiet; s_begin |-> ##1 (!serial_result_output_en)[*4];
    endproperty
    a_quiet: assert property (p_quiet) else $error("driven early");
    property p_mode; $changed(chain_mode) |-> ##[0:2] converting; endproperty
    a_mode: assert property (p_mode) else $error("mode change");
    property p_shift; $changed(serial_result_output) && serial_result_output_en
        && $past(serial_result_output_en) |-> !$past(shift_clock, 2);
    endproperty
    a_shift: assert property (p_shift) else $error("bit moved");
    property p_sbit; $rose(serial_result_output_en) && start_bit_enabled
        |-> serial_result_output == START_BIT_VAL;
    endproperty
    a_sbit: assert property (p_sbit) else $error("start bit");
endmodule : adc_readout_assertions
`default_nettype wire

// *** testbench/adc_readout_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_readout_control_tb;
    import adc_readout_pkg::*;
    logic clock = 1'b0;
    logic rst, convert_strobe, select_chain_input, shift_clock;
    logic serial_result_output, serial_result_output_en, converting;
    logic powered_down, chain_mode, start_bit_enabled;
    logic signed [RAW_W-1:0] raw_code;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 32'h2092;
    logic [5:0] modes [7] = '{6'h26, 6'h24, 6'h27, 6'h23, 6'h02, 6'h12, 6'h0e};
    int nbits [7] = '{16, 17, 16, 17, 32, 17, 16};
    logic signed [RAW_W-1:0] corners [10] = '{18'sh1ffff, 18'sh20000,
        18'sh08000, 18'sh07fff, 18'sh00000, 18'sh00001, 18'sh3ffff,
        18'sh38000, 18'sh37fff, 18'sh38001};
    always #4 clock = ~clock;
    adc_readout_control dut (.*);
    adc_host_model host (.clock(clock), .sro(serial_result_output),
        .sro_en(serial_result_output_en), .strobe(convert_strobe),
        .sel(select_chain_input), .sck(shift_clock));
    function automatic logic [15:0] clamp(input logic signed [RAW_W-1:0] r);
        if (r > 18'sd32767) return CODE_MAX;
        if (r < -18'sd32768) return CODE_MIN;
        return r[15:0];
    endfunction : clamp
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic conv(input int m, input logic signed [RAW_W-1:0] r);
        logic [31:0] cd, got, e;
        logic [5:0]  f;
        logic        ch;
        f = modes[m];
        ch = !f[5] || f[3];
        cd = (nbits[m] == 32) ? $random(seed) : {32{!ch}};
        e = (nbits[m] == 17) ? {START_BIT_VAL, clamp(r)} : clamp(r);
        if (nbits[m] == 32) e = {clamp(r), cd[31:16]};
        raw_code <= r;
        host.start(f[5], f[4], f[3], f[2], f[1]);
        check("chain_mode", chain_mode, ch);
        check("start_bit_enabled", start_bit_enabled, nbits[m] == 17);
        check("converting", converting, 1'b0);
        check("powered_down", powered_down, 1'b1);
        host.read(nbits[m], f[0], cd, got);
        check("frame", got, e);
        if (!ch) begin
            repeat (8) @(posedge clock);
            check("output enable", serial_result_output_en, 1'b0);
        end
    endtask : conv
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1'b1;
        raw_code = '0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 26; i++) begin
            conv(i % 7, (i < 10) ? corners[i] : RAW_W'($random(seed)));
            $display("test %0d done", i);
        end
        tally_and_finish();
    end
endmodule : adc_readout_control_tb
bind adc_readout_control adc_readout_assertions chk (.*);
`default_nettype wire
